// ### rtl/eps_pkg.sv
// Shared constants for the e-paper serial host port
package eps_pkg;
    localparam int BYTE_W = 8;
    localparam int BITS_4W = 8;
    localparam int BITS_3W = 9;
    localparam logic [7:0] CMD_DATA_START = 8'h10;
    localparam logic [7:0] CMD_REFRESH = 8'h12;
    localparam logic BUSY_N_RESET = 1'b1;
    localparam int REFRESH_CYCLES_DEFAULT = 1000;
    localparam logic [15:0] RAM_ADDR_RESET = 16'h0000;
endpackage

// ### rtl/eps_buffer.sv
// Two-entry valid/ready buffer carrying qualified bytes
`timescale 1ns/100ps
module eps_buffer #(
    parameter int WIDTH = 9
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    logic [WIDTH-1:0] slot0_reg;
    logic [WIDTH-1:0] slot1_reg;
    logic [1:0] count_reg;
    logic push;
    logic pop;

    // Handshake terms; ready comes from the count so full is honest
    assign inReady = (count_reg != 2'd2);
    assign outValid = (count_reg != 2'd0);
    assign outData = slot0_reg;
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // Storage: slot0 is always the head
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            slot0_reg <= '0;
            slot1_reg <= '0;
            count_reg <= 2'd0;
        end
        else
        begin
            if (pop)
            begin
                slot0_reg <= slot1_reg;
            end
            if (push)
            begin
                if (count_reg == 2'd0 || (count_reg == 2'd1 && pop))
                begin
                    slot0_reg <= inData;
                end
                else
                begin
                    slot1_reg <= inData;
                end
            end
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// ### rtl/eps_serial_port.sv
// Write-only serial host port: shifter, byte routing, RAM write and refresh busy
//
// Function
// - Strap high selects four-wire format; low selects three-wire nine-bit format.
// - Four-wire: chip select low; select pin low means command, high means data.
// - Data input is sampled on each serial clock rising edge while selected.
// - Bytes arrive most significant bit first, shifted from bit 7 to bit 0.
// - A completed byte goes to display RAM or command register per its qualifier.
// - Write only: no read path, data line never driven back.
// - Three-wire: nine bits per transfer, qualifier flag then bits 7 to 0.
// - Three-wire: flag 1 routes byte to RAM, flag 0 to command register.
// - Three-wire: select pin is ignored; qualifier comes only from the stream.
// - After data start command, data bytes fill RAM until another command.
// - Refresh command drives busy low until refresh completes, then high.
`timescale 1ns/100ps
module eps_serial_port #(
    parameter int REFRESH_CYCLES = eps_pkg::REFRESH_CYCLES_DEFAULT,
    parameter int ADDR_W = 16
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic interfaceSelectStrap,
    input wire logic serialClk,
    input wire logic serialDataIn,
    input wire logic chipSelectN,
    input wire logic dataCmdSel,
    input wire logic sinkReady,
    output logic cmdValid,
    output logic [7:0] cmdByte,
    output logic ramWrite,
    output logic [ADDR_W-1:0] ramAddr,
    output logic [7:0] ramData,
    output logic busyN,
    output logic fourWireMode,
    output logic dataDropped
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] sclkSync_reg;
    logic [1:0] sdiSync_reg;
    logic [1:0] csSync_reg;
    logic [1:0] dcSync_reg;
    logic [1:0] strapSync_reg;
    logic sclkLast_reg;

    // Two stages on every pin; only the second stage is used downstream
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            sclkSync_reg <= 2'b00;
            sdiSync_reg <= 2'b00;
            csSync_reg <= 2'b11;
            dcSync_reg <= 2'b00;
            strapSync_reg <= 2'b00;
            sclkLast_reg <= 1'b0;
        end
        else
        begin
            sclkSync_reg <= {sclkSync_reg[0], serialClk};
            sdiSync_reg <= {sdiSync_reg[0], serialDataIn};
            csSync_reg <= {csSync_reg[0], chipSelectN};
            dcSync_reg <= {dcSync_reg[0], dataCmdSel};
            strapSync_reg <= {strapSync_reg[0], interfaceSelectStrap};
            sclkLast_reg <= sclkSync_reg[1];
        end
    end

    logic sclkRise;
    logic selected;
    // Select and clock edge come from the second stages only
    assign selected = ~csSync_reg[1];
    assign sclkRise = sclkSync_reg[1] & ~sclkLast_reg;

    // ------------------------------------------------------------
    // Format select
    // ------------------------------------------------------------
    logic [1:0] strapWarm_reg;
    logic strapDone_reg;
    logic fourWire_reg;

    // Warm-up marks when the strap synchroniser holds a pin sample, not its reset value
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            strapWarm_reg <= 2'b00;
        end
        else
        begin
            strapWarm_reg <= {strapWarm_reg[0], 1'b1};
        end
    end

    // Strap caught once after warm-up; a later strap change is ignored until the next reset
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            strapDone_reg <= 1'b0;
            fourWire_reg <= 1'b0;
        end
        else if (!strapDone_reg && strapWarm_reg[1])
        begin
            strapDone_reg <= 1'b1;
            fourWire_reg <= strapSync_reg[1];
        end
    end

    // Captured format is visible to the system side
    assign fourWireMode = fourWire_reg;

    // ------------------------------------------------------------
    // Shift register and bit counter
    // ------------------------------------------------------------
    logic [8:0] shift_reg;
    logic [3:0] bitCount_reg;
    logic byteDone;
    logic [3:0] lastBit;
    logic [8:0] shiftNext;

    // Frame length follows the captured format
    assign lastBit = fourWire_reg ? 4'(eps_pkg::BITS_4W - 1) : 4'(eps_pkg::BITS_3W - 1);
    assign shiftNext = {shift_reg[7:0], sdiSync_reg[1]};
    assign byteDone = selected && sclkRise && (bitCount_reg == lastBit) && strapDone_reg;

    // Sample on rising serial clock while selected; deselect clears the count
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            shift_reg <= 9'h000;
            bitCount_reg <= 4'h0;
        end
        else if (!selected)
        begin
            bitCount_reg <= 4'h0;
        end
        else if (sclkRise && strapDone_reg)
        begin
            shift_reg <= shiftNext;
            if (bitCount_reg == lastBit)
            begin
                bitCount_reg <= 4'h0;
            end
            else
            begin
                bitCount_reg <= bitCount_reg + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Qualified byte into buffer
    // ------------------------------------------------------------
    logic isData;
    logic [8:0] wordIn;
    logic bufInReady;
    logic bufOutValid;
    logic bufOutReady;
    logic [8:0] bufOutData;

    // Four-wire uses the pin, three-wire the leading flag; pin ignored then
    assign isData = fourWire_reg ? dcSync_reg[1] : shiftNext[8];
    assign wordIn = {isData, shiftNext[7:0]};

    eps_buffer #(
        .WIDTH(9)
    ) uBuffer (
        .sys_clk(sys_clk),
        .rst(rst),
        .inValid(byteDone),
        .inReady(bufInReady),
        .inData(wordIn),
        .outValid(bufOutValid),
        .outReady(bufOutReady),
        .outData(bufOutData)
    );

    // Serial host cannot be stalled; an overrun is flagged sticky until reset
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            dataDropped <= 1'b0;
        end
        else if (byteDone && !bufInReady)
        begin
            dataDropped <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Byte dispatch
    // ------------------------------------------------------------
    logic ramOpen_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic popWord;
    logic popCmd;
    logic popData;

    // Outputs are registered; data drains only when the sink is ready
    assign bufOutReady = sinkReady;
    assign popWord = bufOutValid && bufOutReady;
    assign popCmd = popWord && !bufOutData[8];
    assign popData = popWord && bufOutData[8];

    // Command register: one-cycle strobe, byte held until the next command
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            cmdValid <= 1'b0;
            cmdByte <= 8'h00;
        end
        else
        begin
            cmdValid <= popCmd;
            if (popCmd)
            begin
                cmdByte <= bufOutData[7:0];
            end
        end
    end

    // Any command ends a RAM stream; only data start opens a new one
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ramOpen_reg <= 1'b0;
        end
        else if (popCmd)
        begin
            ramOpen_reg <= (bufOutData[7:0] == eps_pkg::CMD_DATA_START);
        end
    end

    // Address restarts at every command, so each stream fills from the base
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            addr_reg <= eps_pkg::RAM_ADDR_RESET[ADDR_W-1:0];
        end
        else if (popCmd)
        begin
            addr_reg <= eps_pkg::RAM_ADDR_RESET[ADDR_W-1:0];
        end
        else if (popData && ramOpen_reg)
        begin
            addr_reg <= addr_reg + {{(ADDR_W-1){1'b0}}, 1'b1}; // Wraps at the top
        end
    end

    // RAM write port; data outside an open stream is dropped without a trace
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ramWrite <= 1'b0;
            ramAddr <= eps_pkg::RAM_ADDR_RESET[ADDR_W-1:0];
            ramData <= 8'h00;
        end
        else
        begin
            ramWrite <= popData && ramOpen_reg;
            if (popData && ramOpen_reg)
            begin
                ramAddr <= addr_reg;
                ramData <= bufOutData[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Refresh busy
    // ------------------------------------------------------------
    logic [31:0] refreshCount_reg;

    // Busy low for a fixed refresh time; stands in for the panel waveform engine
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            busyN <= eps_pkg::BUSY_N_RESET;
            refreshCount_reg <= 32'h0000_0000;
        end
        else if (popCmd
            && bufOutData[7:0] == eps_pkg::CMD_REFRESH)
        begin
            busyN <= 1'b0;
            refreshCount_reg <= 32'(REFRESH_CYCLES);
        end
        else if (!busyN)
        begin
            if (refreshCount_reg <= 32'h0000_0001)
            begin
                busyN <= 1'b1;
            end
            refreshCount_reg <= refreshCount_reg - 32'h0000_0001;
        end
    end

    // No serial output port exists at all, so nothing can drive back.
endmodule

// ### testbench/eps_assertions.sv
// Checker on the serial host port outputs
`timescale 1ns/100ps
module eps_checker #(
    parameter int REFRESH_CYCLES = 40,
    parameter int ADDR_W = 16
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cmdValid,
    input wire logic [7:0] cmdByte,
    input wire logic ramWrite,
    input wire logic [ADDR_W-1:0] ramAddr,
    input wire logic [7:0] ramData,
    input wire logic busyN,
    input wire logic dataDropped
);
    localparam int BUSY_MAX = REFRESH_CYCLES + 2;
    logic open_reg;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // Gate seen from outside: data start opens it, other commands close it
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            open_reg <= 1'b0;
        else if (cmdValid)
            open_reg <= (cmdByte == eps_pkg::CMD_DATA_START);
    end
    // Back-to-back drains after a stall are legal, so strobes are not forced to one cycle
    a_one_target: assert property (cmdValid |-> !ramWrite) else $error("two targets");
    a_ram_step: assert property (ramWrite |=> !ramWrite
        || ramAddr == $past(ramAddr) + {{(ADDR_W-1){1'b0}}, 1'b1})
        else $error("address step");
    a_ram_gated: assert property (ramWrite |-> open_reg) else $error("write ungated");
    a_cmd_hold: assert property (!cmdValid |-> $stable(cmdByte)) else $error("cmd moved");
    a_data_hold: assert property (!ramWrite |-> $stable(ramData) && $stable(ramAddr))
        else $error("data moved");
    a_busy_start: assert property (cmdValid && cmdByte == eps_pkg::CMD_REFRESH |-> !busyN)
        else $error("busy not low");
    a_busy_cause: assert property ($fell(busyN) |-> cmdValid && cmdByte == eps_pkg::CMD_REFRESH)
        else $error("busy without cmd");
    a_busy_span: assert property ($fell(busyN) |-> !busyN[*8] ##[1:BUSY_MAX] busyN)
        else $error("busy length");
    a_drop_sticky: assert property (dataDropped |=> dataDropped) else $error("drop cleared");
endmodule
bind eps_serial_port eps_checker #(.REFRESH_CYCLES(REFRESH_CYCLES), .ADDR_W(ADDR_W)) i_eps_checker (
    .sys_clk(sys_clk), .rst(rst), .cmdValid(cmdValid), .cmdByte(cmdByte),
    .ramWrite(ramWrite), .ramAddr(ramAddr), .ramData(ramData), .busyN(busyN),
    .dataDropped(dataDropped));

// ### testbench/eps_host_model.sv
// Host microcontroller model driving the serial port
`timescale 1ns/100ps
module eps_host_model (
    input wire logic sys_clk,
    input wire logic fourWire,
    output logic serialClk,
    output logic serialDataIn,
    output logic chipSelectN,
    output logic dataCmdSel
);
    // Idle: deselected, clock parked low
    initial
    begin
        serialClk = 1'b0;
        serialDataIn = 1'b0;
        chipSelectN = 1'b1;
        dataCmdSel = 1'b0;
    end
    // Four cycles per phase: the pins are oversampled by the port
    task automatic hold();
        repeat (4) @(negedge sys_clk);
    endtask
    // Sends nBits of a frame; a short count aborts it mid-way
    task automatic sendFrame(input logic dc, input logic [7:0] b, input int nBits);
        logic [8:0] w;
        int top;
        w = {dc, b};
        top = fourWire ? 7 : 8;
        @(negedge sys_clk);
        chipSelectN = 1'b0;
        // Board ties the pin low in three-wire, so data can only route by the flag
        dataCmdSel = fourWire ? dc : 1'b0;
        for (int k = 0; k < nBits; k++)
        begin
            serialDataIn = w[top-k];
            hold();
            serialClk = 1'b1;
            hold();
            serialClk = 1'b0;
        end
        hold();
        chipSelectN = 1'b1;
        serialDataIn = !serialDataIn; // Released line shows no stale bit
        hold();
    endtask
endmodule

// ### testbench/tb.sv
// Testbench for the serial host port
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module tb;
    logic sys_clk, rst, strap, sinkReady, serialClk, serialDataIn, chipSelectN, dataCmdSel;
    logic cmdValid, ramWrite, busyN, fourWireMode, dataDropped;
    logic [7:0] cmdByte, ramData;
    logic [15:0] ramAddr;
    logic [7:0] cmdQ[$];
    logic [23:0] ramQ[$];
    int n_mismatch, checks_done;
    eps_serial_port #(.REFRESH_CYCLES(40)) i_eps_serial_port (.sys_clk(sys_clk), .rst(rst),
        .interfaceSelectStrap(strap), .serialClk(serialClk), .serialDataIn(serialDataIn),
        .chipSelectN(chipSelectN), .dataCmdSel(dataCmdSel), .sinkReady(sinkReady),
        .cmdValid(cmdValid), .cmdByte(cmdByte), .ramWrite(ramWrite), .ramAddr(ramAddr),
        .ramData(ramData), .busyN(busyN), .fourWireMode(fourWireMode),
        .dataDropped(dataDropped));
    eps_host_model i_eps_host_model (.sys_clk(sys_clk), .fourWire(strap),
        .serialClk(serialClk), .serialDataIn(serialDataIn), .chipSelectN(chipSelectN),
        .dataCmdSel(dataCmdSel));
    // ---------------- Clock and monitor ----------------
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // Strobes are caught mid-cycle, where they have settled
    always @(negedge sys_clk)
    begin
        if (cmdValid === 1'b1)
            cmdQ.push_back(cmdByte);
        if (ramWrite === 1'b1)
            ramQ.push_back({ramAddr, ramData});
    end
    // ---------------- Tasks ----------------
    task automatic stop_test();
        $display("Mismatches %0d, checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic resetDut(input logic s);
        strap = s;
        rst = 1'b1;
        repeat (8) @(negedge sys_clk);
        rst = 1'b0;
        repeat (4) @(negedge sys_clk);
    endtask
    task automatic tx(input logic dc, input logic [7:0] b);
        i_eps_host_model.sendFrame(dc, b, strap ? 8 : 9);
        repeat (6) @(negedge sys_clk);
    endtask
    task automatic expC(input logic [7:0] b);
        logic [7:0] v;
        v = cmdQ.size() ? cmdQ.pop_front() : 8'hxx;
        `CHK(v, b)
    endtask
    task automatic expR(input logic [15:0] a, input logic [7:0] d);
        logic [23:0] v;
        v = ramQ.size() ? ramQ.pop_front() : 24'hxx_xxxx;
        `CHK(v, {a, d})
    endtask
    // Hang guard, well past the expected run
    initial
    begin
        #300us;
        n_mismatch++;
        stop_test();
    end
    // ---------------- Tests ----------------
    initial
    begin
        n_mismatch = 0;
        checks_done = 0;
        rst = 1'b1;
        strap = 1'b1;
        sinkReady = 1'b1;
        resetDut(1'b1);
        `CHK(fourWireMode, 1'b1)
        `CHK(busyN, eps_pkg::BUSY_N_RESET)
        tx(1'b1, 8'hEE); // Data before start must vanish
        tx(1'b0, eps_pkg::CMD_DATA_START);
        expC(eps_pkg::CMD_DATA_START);
        tx(1'b1, 8'hA5);
        i_eps_host_model.sendFrame(1'b1, 8'h3C, 3);
        tx(1'b1, 8'h3C);
        expR(16'h0000, 8'hA5);
        expR(16'h0001, 8'h3C);
        `CHK(ramQ.size() == 0, 1'b1)
        sinkReady = 1'b0; // Stall: two words fit, the third is lost
        tx(1'b1, 8'h11);
        tx(1'b1, 8'h22);
        tx(1'b1, 8'h33);
        `CHK(dataDropped, 1'b1)
        sinkReady = 1'b1;
        repeat (8) @(negedge sys_clk);
        expR(16'h0002, 8'h11);
        expR(16'h0003, 8'h22);
        tx(1'b0, eps_pkg::CMD_REFRESH);
        expC(eps_pkg::CMD_REFRESH);
        `CHK(busyN, 1'b0)
        repeat (40) @(negedge sys_clk);
        `CHK(busyN, 1'b1)
        resetDut(1'b0);
        `CHK(fourWireMode, 1'b0)
        `CHK(ramAddr, eps_pkg::RAM_ADDR_RESET)
        tx(1'b0, eps_pkg::CMD_DATA_START);
        tx(1'b1, 8'h5A);
        tx(1'b1, 8'hC3);
        tx(1'b0, eps_pkg::CMD_REFRESH);
        expC(eps_pkg::CMD_DATA_START);
        expR(16'h0000, 8'h5A);
        expR(16'h0001, 8'hC3);
        expC(eps_pkg::CMD_REFRESH);
        stop_test();
    end
endmodule
